// *** alacc_core.sv ***
`default_nettype none
module alacc_core
   import alacc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             instr_valid,
   input  wire logic [9:0]       instr,
   input  wire logic [3:0]       ram_rdata,
   input  wire logic [3:0]       clock_control_reg,
   input  wire logic [3:0]       pullup_control_reg0,
   input  wire logic             carry_in,
   output logic       [3:0]      acc,
   output alacc_ptr_t            ram_data_pointer,
   output logic                  carry_flag,
   output logic                  done
);
   // Accumulator state.
   logic [3:0]  acc_reg;
   logic [3:0]  acc_next;

   // Data pointer state; only its X part is ever moved here.
   alacc_ptr_t  ptr_reg;
   alacc_ptr_t  ptr_next;

   // Status state: the carry copy and the completion pulse.
   logic        carry_reg;
   logic        carry_next;
   logic        done_reg;
   logic        done_next;

   // Decode results; op is shared by all three state groups, imm and x_flipped feed only the pointer.
   alacc_op_t   op;
   logic [3:0]  imm;
   logic [3:0]  x_flipped;

   // Sorts a word into one of the three loads or into nothing. The memory load
   // is matched on its upper six bits only, because its low four bits carry the
   // immediate; the two register loads must match all ten bits, so a word one
   // bit away from either of them is ignored rather than half executed.
   function automatic alacc_op_t decode(input logic [9:0] w);
      if (w[9:4] == ALACC_OP_RAM_XOR) begin
         decode = ALACC_RAM;
      end else if (w == ALACC_OP_CLK) begin
         decode = ALACC_CLK;
      end else if (w == ALACC_OP_PULLUP0) begin
         decode = ALACC_PULLUP0;
      end else begin
         decode = ALACC_NONE;
      end
   endfunction

   // An unqualified slot decodes to nothing, so a word left standing on the
   // instruction lines between slots can never be executed a second time.
   assign op  = instr_valid ? decode(instr) : ALACC_NONE;
   assign imm = instr[3:0];

   // One exclusive OR per bit of X; the immediate may flip any mix of them.
   for (genvar b = 0; b < 4; b++) begin : g_x_flip
      assign x_flipped[b] = ptr_reg.x[b] ^ imm[b];
   end

   // Accumulator next value. The memory nibble arrives for the pointer as it
   // stands in this cycle, so the load always sees the pointer before its
   // update, even though both land on the same clock edge.
   always_comb begin
      acc_next = acc_reg;
      case (op)
         ALACC_RAM: begin
            acc_next = ram_rdata;
         end
         ALACC_CLK: begin
            acc_next = clock_control_reg;
         end
         ALACC_PULLUP0: begin
            acc_next = pullup_control_reg0;
         end
         default: begin
            acc_next = acc_reg;
         end
      endcase
   end

   // Accumulator register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_reg <= ALACC_ACC_RST;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // Pointer next value. Only X moves; the rest of the pointer is held, so a
   // run of memory loads walks within one row and never drifts to another.
   always_comb begin
      ptr_next = ptr_reg;
      case (op)
         ALACC_RAM: begin
            ptr_next.x = x_flipped;
         end
         default: begin
            ptr_next = ptr_reg;
         end
      endcase
   end

   // Pointer register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_reg.x  <= ALACC_X_RST;
         ptr_reg.yz <= ALACC_YZ_RST;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // Status next values. None of these loads alters the carry, so the flag
   // just follows the core's carry one cycle late; done marks a taken word.
   // The limitation is that a carry change made elsewhere shows here a cycle
   // late, which is the price of keeping every output on a flip-flop.
   always_comb begin
      carry_next = carry_in;
      done_next  = ALACC_DONE_RST;
      case (op)
         ALACC_RAM: begin
            done_next = 1'h1;
         end
         ALACC_CLK: begin
            done_next = 1'h1;
         end
         ALACC_PULLUP0: begin
            done_next = 1'h1;
         end
         default: begin
            done_next = ALACC_DONE_RST;
         end
      endcase
   end

   // Status registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         carry_reg <= ALACC_CARRY_RST;
         done_reg  <= ALACC_DONE_RST;
      end else begin
         carry_reg <= carry_next;
         done_reg  <= done_next;
      end
   end

   // Every output comes straight from its register.
   assign acc              = acc_reg;
   assign ram_data_pointer = ptr_reg;
   assign carry_flag       = carry_reg;
   assign done             = done_reg;

   // The checks below decode the raw word themselves instead of reusing the
   // decode function, so that a fault in the decoder cannot hide itself.

   // The accumulator takes the nibble that stood at the old pointer.
   ram_load_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr[9:4] == ALACC_OP_RAM_XOR)
      |=> acc == $past(ram_rdata))
      else $error("Memory load took the wrong nibble.");

   // X flips by the immediate and nothing else in the pointer moves.
   ptr_xor_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr[9:4] == ALACC_OP_RAM_XOR)
      |=> ram_data_pointer.x == ($past(ram_data_pointer.x) ^ $past(instr[3:0]))
         && $stable(ram_data_pointer.yz))
      else $error("Pointer X update wrong.");

   // Every immediate value is taken as a memory load within one cycle.
   ram_done_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr[9:4] == ALACC_OP_RAM_XOR)
      |=> done)
      else $error("Memory load not completed.");

   // The clock control value lands in the accumulator in one cycle.
   clk_load_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr == ALACC_OP_CLK)
      |=> acc == $past(clock_control_reg) && done)
      else $error("Clock control load wrong.");

   // The clock control load leaves the carry and the pointer alone.
   clk_side_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr == ALACC_OP_CLK)
      |=> carry_flag == $past(carry_in) && $stable(ram_data_pointer))
      else $error("Clock control load disturbed other state.");

   // The pull-up value lands in the accumulator in one cycle.
   pullup_load_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr == ALACC_OP_PULLUP0)
      |=> acc == $past(pullup_control_reg0) && done)
      else $error("Pull-up load wrong.");

   // The pull-up load leaves the carry and the pointer alone.
   pullup_side_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr == ALACC_OP_PULLUP0)
      |=> carry_flag == $past(carry_in) && $stable(ram_data_pointer))
      else $error("Pull-up load disturbed other state.");

   // The carry is never changed by this block in any slot.
   carry_follow_a: assert property (@(posedge clk) disable iff (rst)
      1'h1 |=> carry_flag == $past(carry_in))
      else $error("Carry altered.");

   // An empty slot changes nothing and completes nothing.
   idle_hold_a: assert property (@(posedge clk) disable iff (rst)
      !instr_valid |=> $stable(acc) && $stable(ram_data_pointer) && !done)
      else $error("State changed without instruction.");

   // A word outside the three loads is refused without a trace.
   foreign_hold_a: assert property (@(posedge clk) disable iff (rst)
      (instr_valid && instr[9:4] != ALACC_OP_RAM_XOR && instr != ALACC_OP_CLK
         && instr != ALACC_OP_PULLUP0)
      |=> $stable(acc) && $stable(ram_data_pointer) && !done)
      else $error("Foreign word changed state.");

   // Completion only ever follows a qualified slot.
   done_source_a: assert property (@(posedge clk) disable iff (rst)
      done |-> $past(instr_valid))
      else $error("Completion without a slot.");
endmodule
`default_nettype wire

// *** alacc_pkg.sv ***
`default_nettype none
package alacc_pkg;
   localparam int          ALACC_IW         = 10;
   localparam int          ALACC_DW         = 4;
   localparam logic [5:0]  ALACC_OP_RAM_XOR = 6'h2C;
   localparam logic [9:0]  ALACC_OP_CLK     = 10'h252;
   localparam logic [9:0]  ALACC_OP_PULLUP0 = 10'h257;
   localparam logic [3:0]  ALACC_ACC_RST    = 4'h0;
   localparam logic [3:0]  ALACC_X_RST      = 4'h0;
   localparam logic [3:0]  ALACC_YZ_RST     = 4'h0;
   localparam logic        ALACC_CARRY_RST  = 1'h0;
   localparam logic        ALACC_DONE_RST   = 1'h0;

   // Decoded operation, one-hot.
   typedef enum logic [3:0] {
      ALACC_NONE    = 4'h1,
      ALACC_RAM     = 4'h2,
      ALACC_CLK     = 4'h4,
      ALACC_PULLUP0 = 4'h8
   } alacc_op_t;

   // Data pointer with its X part separate from the rest.
   typedef struct packed {
      logic [3:0] x;
      logic [3:0] yz;
   } alacc_ptr_t;
endpackage
`default_nettype wire

// *** test_alacc_core.sv ***
`default_nettype none
module test_alacc_core
   import alacc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, instr_valid, carry_in, carry_flag, done;
   logic [9:0] instr;
   logic [3:0] ram_rdata, clk_ctl, pullup0, acc, ex_acc, ex_x;
   alacc_ptr_t ptr;
   int         n_fail, cmp_count;
   // RAM model: the nibble depends on the pointer so a stale pointer shows.
   assign ram_rdata = ptr.x ^ 4'h9;
   alacc_core uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .ram_rdata(ram_rdata), .clock_control_reg(clk_ctl), .pullup_control_reg0(pullup0),
      .carry_in(carry_in), .acc(acc), .ram_data_pointer(ptr), .carry_flag(carry_flag),
      .done(done));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One instruction slot; hit says whether the word must be taken.
   task automatic exec(input logic [9:0] i, input logic v, input logic hit, input logic [3:0] s,
                       input logic [3:0] nx);
      instr = i;
      instr_valid = v;
      carry_in = ~carry_in;
      @(posedge clk);
      #2;
      if (hit) ex_acc = s;
      if (hit) ex_x = nx;
      chk("acc", {4'h0, ex_acc}, {4'h0, acc});
      chk("ptr", {ex_x, 4'h0}, ptr);
      chk("done", {7'h0, hit}, {7'h0, done});
      chk("carry", {7'h0, carry_in}, {7'h0, carry_flag});
   endtask
   // Every immediate back to back, checking the read uses the old pointer.
   task automatic t_ram();
      for (int j = 0; j < 16; j++) exec({6'h2C, 4'(j)}, 1'b1, 1'b1, ex_x ^ 4'h9, ex_x ^ 4'(j));
   endtask
   task automatic t_regs();
      clk_ctl = 4'hB;
      pullup0 = 4'h6;
      exec(ALACC_OP_CLK, 1'b1, 1'b1, 4'hB, ex_x);
      exec(ALACC_OP_PULLUP0, 1'b1, 1'b1, 4'h6, ex_x);
   endtask
   // Reset in mid-run, with X moved first, must restore every output.
   task automatic t_reset();
      exec({6'h2C, 4'h5}, 1'b1, 1'b1, ex_x ^ 4'h9, ex_x ^ 4'h5);
      instr_valid = 1'h0;
      rst = 1'h1;
      repeat (2) @(posedge clk);
      #2;
      ex_acc = ALACC_ACC_RST;
      ex_x = ALACC_X_RST;
      chk("acc", {4'h0, ex_acc}, {4'h0, acc});
      chk("ptr", {ex_x, ALACC_YZ_RST}, ptr);
      chk("done", 8'h00, {7'h0, done});
      chk("carry", 8'h00, {7'h0, carry_flag});
      rst = 1'h0;
   endtask
   // Neighbouring words and an unqualified slot must change nothing.
   task automatic t_refuse();
      exec(10'h253, 1'b1, 1'b0, 4'h0, 4'h0);
      exec(10'h2DF, 1'b1, 1'b0, 4'h0, 4'h0);
      exec(10'h2C7, 1'b0, 1'b0, 4'h0, 4'h0);
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      rst = 1'h1;
      instr_valid = 1'h0;
      carry_in = 1'h0;
      instr = 10'h000;
      clk_ctl = 4'h0;
      pullup0 = 4'h0;
      ex_acc = ALACC_ACC_RST;
      ex_x = ALACC_X_RST;
      n_fail = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      #2 rst = 1'b0;
      t_ram();
      t_regs();
      t_refuse();
      t_reset();
      t_ram();
      final_report();
   end
endmodule
`default_nettype wire
